// *** inc/igp_regs.svh ***
/*
 * Timing constants for the inverter gate drive controller.
 * Assumes a 250 MHz mclk; all counts are derived from times in ns.
 */
`ifndef IGP_REGS_SVH
`define IGP_REGS_SVH

// Clock period in ns
`define IGP_CLK_PERIOD_NS        4
// Leg blanking time, ns (least time, rounds up)
`define IGP_LEG_BLANKING_NS      1000
`define IGP_LEG_BLANKING_CYC     ((`IGP_LEG_BLANKING_NS + `IGP_CLK_PERIOD_NS - 1) / `IGP_CLK_PERIOD_NS)
// Minimum on and off widths, ns (least time, rounds up)
`define IGP_MIN_WIDTH_NS         700
`define IGP_MIN_WIDTH_CYC        ((`IGP_MIN_WIDTH_NS + `IGP_CLK_PERIOD_NS - 1) / `IGP_CLK_PERIOD_NS)
// Fault pulse least time, ns; watched by the controller
`define IGP_FAULT_PULSE_MIN_NS   20000
`define IGP_FAULT_PULSE_MIN_CYC  ((`IGP_FAULT_PULSE_MIN_NS + `IGP_CLK_PERIOD_NS - 1) / `IGP_CLK_PERIOD_NS)
// Width of the per-gate timing counter
`define IGP_CNT_W                9

`endif

// *** inc/igp_pkg.sv ***
/*
 * Types shared by the gate drive controller.
 * Assumes igp_regs.svh is compiled alongside.
 */
`default_nettype none
package igp_pkg;

  // Six gate requests, high means switch on
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } igp_gates_s;

  // Per-gate pacing state
  typedef enum logic [1:0] {
    IGP_OFF,
    IGP_BLANK,
    IGP_ON
  } igp_gate_e;

endpackage
`default_nettype wire

// *** hdl/igp_leg.sv ***
/*
 * One phase leg pacer: turns the high and low gate requests of a leg into
 * pin levels that keep the blanking interval and the minimum widths.
 * Assumes requests come from logic on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "igp_regs.svh"

module igp_leg #(
  parameter int unsigned BLANK_CYC = `IGP_LEG_BLANKING_CYC,
  parameter int unsigned WIDTH_CYC = `IGP_MIN_WIDTH_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       hi_req,
  input  wire logic       lo_req,
  output logic            hi_pin,
  output logic            lo_pin
);

  localparam int unsigned CW = `IGP_CNT_W;

  logic          hi_q;
  logic          lo_q;
  logic [CW-1:0] hi_age_q;   // Cycles since last change of hi_q
  logic [CW-1:0] lo_age_q;
  logic [CW-1:0] hi_off_q;   // Cycles since hi_q fell
  logic [CW-1:0] lo_off_q;

  // Saturating increment, used for all four age counters
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (v == {CW{1'b1}}) ? v : CW'(v + 1'b1);
  endfunction

  // A change is allowed once the level has stood its minimum width
  logic hi_may, lo_may;
  assign hi_may = hi_age_q >= CW'(WIDTH_CYC - 1); // R13
  assign lo_may = lo_age_q >= CW'(WIDTH_CYC - 1); // R13

  // High gate: turns on only after low has been off for the blanking time
  always_ff @(posedge mclk) begin
    if (rst) begin
      hi_q     <= 1'b0;
      hi_age_q <= '1;
      hi_off_q <= '1;
    end else begin
      if (hi_may && !hi_q && hi_req && !lo_req && !lo_q
          && lo_off_q >= CW'(BLANK_CYC - 1)) begin // R12
        hi_q     <= 1'b1;
        hi_age_q <= '0;
      end else if (hi_may && hi_q && !hi_req) begin
        hi_q     <= 1'b0;
        hi_age_q <= '0;
        hi_off_q <= '0;
      end else begin
        hi_age_q <= sat_inc(hi_age_q);
        if (!hi_q) hi_off_q <= sat_inc(hi_off_q);
      end
    end
  end

  // Low gate mirrors the high gate; neither turns on if both request
  always_ff @(posedge mclk) begin
    if (rst) begin
      lo_q     <= 1'b0;
      lo_age_q <= '1;
      lo_off_q <= '1;
    end else begin
      if (lo_may && !lo_q && lo_req && !hi_req && !hi_q
          && hi_off_q >= CW'(BLANK_CYC - 1)) begin // R12
        lo_q     <= 1'b1;
        lo_age_q <= '0;
      end else if (lo_may && lo_q && !lo_req) begin
        lo_q     <= 1'b0;
        lo_age_q <= '0;
        lo_off_q <= '0;
      end else begin
        lo_age_q <= sat_inc(lo_age_q);
        if (!lo_q) lo_off_q <= sat_inc(lo_off_q);
      end
    end
  end

  assign hi_pin = hi_q; // R14
  assign lo_pin = lo_q; // R14

  // Never both switches of the leg on
  a_leg_no_overlap: assert property (@(posedge mclk) disable iff (rst) // R12
    !(hi_q && lo_q)) else $error("both gates of a leg on");

  // High turns on only after low was off for the blanking time
  a_leg_blank_hi: assert property (@(posedge mclk) disable iff (rst) // R12
    $rose(hi_q) |-> $past(lo_off_q) >= CW'(BLANK_CYC - 1))
    else $error("high gate on inside blanking time");

  // Low turns on only after high was off for the blanking time
  a_leg_blank_lo: assert property (@(posedge mclk) disable iff (rst) // R12
    $rose(lo_q) |-> $past(hi_off_q) >= CW'(BLANK_CYC - 1))
    else $error("low gate on inside blanking time");

  // High on pulses hold at least the minimum width
  a_leg_on_width: assert property (@(posedge mclk) disable iff (rst) // R13
    $fell(hi_q) |-> $past(hi_age_q) >= CW'(WIDTH_CYC - 1))
    else $error("high on pulse too short");

  // Low off pulses hold at least the minimum width
  a_leg_off_width: assert property (@(posedge mclk) disable iff (rst) // R13
    $rose(lo_q) |-> $past(lo_age_q) >= CW'(WIDTH_CYC - 1))
    else $error("low off pulse too short");

endmodule
`default_nettype wire

// *** hdl/igp_ctrl.sv ***
/*
 * Gate drive controller for a three phase inverter module with built-in
 * protection. Paces six active high gate pins and watches the module's
 * open-drain fault line, whose pull-up the controller enables on pull_up_en.
 * Assumes the fault pin is asynchronous and the requests are on mclk.
 */
// Contract
// R1: Low-side overcurrent forces all low gates off
// R2: Overcurrent fault pulse lasts at least 20us
// R3: Tripped switch resumes only on new edge
// R4: Re-arming happens per phase, independently
// R5: Low supply undervoltage forces low gates off
// R6: Undervoltage/overheat fault lasts while condition persists
// R7: After supply recovery, low gate needs edge
// R8: High supply undervoltage: that high off, no fault
// R9: After high supply recovery, high needs edge
// R10: Overheat forces low gates off, asserts fault
// R11: After cooling, low gates need fresh edge
// R12: Controller keeps 1.0us blanking between leg switches
// R13: Controller keeps on/off pulses at least 0.7us
// R14: Gate inputs active high, pulled down
// R15: Fault open-drain, controller supplies pull-up
// R16: Overlapping faults keep fault until all clear
`timescale 1ns/1ps
`default_nettype none
`include "igp_regs.svh"

module igp_ctrl #(
  parameter int unsigned BLANK_CYC = `IGP_LEG_BLANKING_CYC,
  parameter int unsigned WIDTH_CYC = `IGP_MIN_WIDTH_CYC,
  parameter int unsigned FAULT_CYC = `IGP_FAULT_PULSE_MIN_CYC
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire igp_pkg::igp_gates_s req,
  input  wire logic               fault_out_n,
  output igp_pkg::igp_gates_s     gate,
  output logic                    fault_seen,
  output logic                    fault_event,
  output logic                    fault_long,
  output logic                    pull_up_en
);

  // ***************************************************************
  // Fault pin synchroniser and tracking
  // ***************************************************************
  logic        flt_s1_q;
  logic        flt_s2_q;
  logic        flt_prev_q;
  logic [15:0] flt_cnt_q;

  // Two flops before anything reads the fault pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      flt_s1_q <= 1'b0;
      flt_s2_q <= 1'b0;
    end else begin
      // The pin floats until the pull-up is on; ignore it until then
      flt_s1_q <= ~fault_out_n & pull_up_en;
      flt_s2_q <= flt_s1_q;
    end
  end

  // Length of the current fault low period; tells short from held faults
  always_ff @(posedge mclk) begin
    if (rst) begin
      flt_prev_q <= 1'b0;
      flt_cnt_q  <= '0;
    end else begin
      flt_prev_q <= flt_s2_q;
      if (!flt_s2_q) flt_cnt_q <= '0;
      else if (flt_cnt_q != 16'hffff) flt_cnt_q <= flt_cnt_q + 16'h0001;
    end
  end

  // ***************************************************************
  // Request gating
  // ***************************************************************
  // Low requests are dropped while the module reports a fault and held off
  // until software lowers them: the module itself also waits for an edge, so
  // a request left high would otherwise look on but drive nothing.
  logic [2:0] lo_block_q;
  logic [2:0] hi_req_g;
  logic [2:0] lo_req_g;

  always_ff @(posedge mclk) begin
    if (rst) begin
      lo_block_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (flt_s2_q) lo_block_q[i] <= 1'b1; // R1 R5 R10
        else if (!req.low[i]) lo_block_q[i] <= 1'b0; // R3 R4 R7 R11
      end
    end
  end

  assign lo_req_g = req.low & ~lo_block_q & {3{~flt_s2_q}};
  assign hi_req_g = req.high; // R8 R9: high-side recovery is the module's own

  // ***************************************************************
  // Phase legs
  // ***************************************************************
  logic [2:0] hi_pin;
  logic [2:0] lo_pin;

  for (genvar g = 0; g < 3; g++) begin : g_leg
    igp_leg #(
      .BLANK_CYC (BLANK_CYC),
      .WIDTH_CYC (WIDTH_CYC)
    ) u_leg (
      .mclk   (mclk),
      .rst    (rst),
      .hi_req (hi_req_g[g]),
      .lo_req (lo_req_g[g]),
      .hi_pin (hi_pin[g]),
      .lo_pin (lo_pin[g])
    );
  end

  // ***************************************************************
  // Registered outputs
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      gate        <= '0;
      fault_seen  <= 1'b0;
      fault_event <= 1'b0;
      fault_long  <= 1'b0;
      pull_up_en  <= 1'b0;
    end else begin
      gate.high   <= hi_pin; // R14
      gate.low    <= lo_pin; // R14
      fault_seen  <= flt_s2_q; // R16
      fault_event <= flt_s2_q & ~flt_prev_q; // R2
      fault_long  <= flt_cnt_q >= 16'(FAULT_CYC); // R6
      pull_up_en  <= 1'b1; // R15
    end
  end

  // Low gates are off two cycles on once a fault has outlasted the on
  // width; a gate that has only just turned on first finishes its width,
  // which the leg keeps.
  a_low_off_fault: assert property (@(posedge mclk) disable iff (rst) // R1
    (flt_s2_q && $past(flt_s2_q, WIDTH_CYC)) |-> ##2 (gate.low == 3'b000))
    else $error("low gate on during fault");

  // A blocked phase stays blocked while its request stays high
  a_rearm_edge: assert property (@(posedge mclk) disable iff (rst) // R3
    (|(lo_block_q & req.low)) |=>
      ((lo_block_q & $past(lo_block_q & req.low)) == $past(lo_block_q & req.low)))
    else $error("low gate rearmed without edge");

  // Fault start is flagged for a single cycle
  a_event_pulse: assert property (@(posedge mclk) disable iff (rst) // R2
    fault_event |=> !fault_event)
    else $error("fault start flag held");

  // Long fault flag only after the report has stood the minimum pulse
  a_long_fault: assert property (@(posedge mclk) disable iff (rst) // R6
    $rose(fault_long) |-> seen_run_q >= MW'(FAULT_CYC))
    else $error("long fault flag early");

  // ***************************************************************
  // Pin timing monitor
  // ***************************************************************
  // Counts, for each gate pin, the cycles its present level has stood.
  // The checks watch the registered pins themselves, so a pacing slip
  // anywhere between the requests and the output flops shows up here,
  // not only inside the legs. Nothing here feeds the outputs.
  localparam int unsigned MW = 16;

  logic [MW-1:0] hi_stand_q [3];  // Cycles since gate.high[i] last moved
  logic [MW-1:0] lo_stand_q [3];  // Cycles since gate.low[i] last moved
  logic [2:0]    hi_last_q;       // gate.high one cycle back
  logic [2:0]    lo_last_q;       // gate.low one cycle back
  logic [MW-1:0] seen_run_q;      // Cycles fault_seen has stood high

  // Saturating count shared by every monitor counter
  function automatic logic [MW-1:0] mon_inc(input logic [MW-1:0] v);
    mon_inc = (v == {MW{1'b1}}) ? v : MW'(v + 1'b1);
  endfunction

  // Pin level ages; a change is seen one cycle after it is launched
  always_ff @(posedge mclk) begin
    if (rst) begin
      hi_last_q <= '0;
      lo_last_q <= '0;
      for (int i = 0; i < 3; i++) begin
        hi_stand_q[i] <= '1;
        lo_stand_q[i] <= '1;
      end
    end else begin
      hi_last_q <= gate.high;
      lo_last_q <= gate.low;
      for (int i = 0; i < 3; i++) begin
        if (gate.high[i] != hi_last_q[i]) hi_stand_q[i] <= '0;
        else hi_stand_q[i] <= mon_inc(hi_stand_q[i]);
        if (gate.low[i] != lo_last_q[i]) lo_stand_q[i] <= '0;
        else lo_stand_q[i] <= mon_inc(lo_stand_q[i]);
      end
    end
  end

  // Length of the present fault report, counted on the output flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      seen_run_q <= '0;
    end else if (fault_seen) begin
      seen_run_q <= mon_inc(seen_run_q);
    end else begin
      seen_run_q <= '0;
    end
  end

  for (genvar m = 0; m < 3; m++) begin : g_mon
    // Each pin level stands its minimum width before it moves again
    a_pin_hi_width: assert property (@(posedge mclk) disable iff (rst) // R13
      (gate.high[m] != hi_last_q[m]) |-> hi_stand_q[m] >= MW'(WIDTH_CYC - 1))
      else $error("high pin level too short");
    a_pin_lo_width: assert property (@(posedge mclk) disable iff (rst) // R13
      (gate.low[m] != lo_last_q[m]) |-> lo_stand_q[m] >= MW'(WIDTH_CYC - 1))
      else $error("low pin level too short");

    // A pin turns on only after its partner pin was off for the blanking time
    a_pin_blank_lo: assert property (@(posedge mclk) disable iff (rst) // R12
      (gate.low[m] && !lo_last_q[m]) |->
        (!gate.high[m] && !hi_last_q[m] && hi_stand_q[m] >= MW'(BLANK_CYC - 1)))
      else $error("low pin on inside blanking time");
    a_pin_blank_hi: assert property (@(posedge mclk) disable iff (rst) // R12
      (gate.high[m] && !hi_last_q[m]) |->
        (!gate.low[m] && !lo_last_q[m] && lo_stand_q[m] >= MW'(BLANK_CYC - 1)))
      else $error("high pin on inside blanking time");
  end

endmodule
`default_nettype wire

// *** tb/igp_dev_model.sv ***
/* Behavioural model of the protected inverter module: switches, trips and
   open-drain fault line. Assumes its inputs change just after mclk rises. */
`timescale 1ns/1ps
`default_nettype none
module igp_dev_model #(
  parameter int PULSE = 20
) (
  input  wire logic                mclk,
  input  wire igp_pkg::igp_gates_s gate,
  input  wire logic                pull_up_en,
  input  wire logic                sc_trip,
  input  wire logic                ld_uv,
  input  wire logic                ot_trip,
  input  wire logic [2:0]          hb_uv,
  output igp_pkg::igp_gates_s      sw,
  output logic                     fault_out_n
);
  // ****************
  // Protection state
  // ****************
  igp_pkg::igp_gates_s prev_q  = '0;
  logic [2:0]          lo_ok_q = 3'h7;
  logic [2:0]          hi_ok_q = 3'h7;
  int unsigned         cnt_q   = 0;
  logic                flt_q   = 1'b0;
  logic                tgl_q   = 1'b0;
  wire                 lo_flt  = sc_trip | ld_uv | ot_trip;
  wire                 sink    = (cnt_q != 0) | ld_uv | ot_trip;
  // Trips block a gate until its own pin rises again after the fault
  always @(posedge mclk) begin
    flt_q  <= lo_flt;
    prev_q <= gate;
    tgl_q  <= ~tgl_q;
    if (lo_flt && !flt_q) cnt_q <= PULSE;
    else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    for (int i = 0; i < 3; i++) begin
      if (lo_flt) lo_ok_q[i] <= 1'b0;
      else if (cnt_q == 0 && gate.low[i] && !prev_q.low[i]) lo_ok_q[i] <= 1'b1;
      if (hb_uv[i]) hi_ok_q[i] <= 1'b0;
      else if (gate.high[i] && !prev_q.high[i]) hi_ok_q[i] <= 1'b1;
    end
  end
  // Forcing off is immediate, not clocked, as the real module is
  assign sw.low      = gate.low & lo_ok_q & {3{~lo_flt}};
  assign sw.high     = gate.high & hi_ok_q & ~hb_uv;
  // Without the pull-up the line floats, shown as a toggling level
  assign fault_out_n = sink ? 1'b0 : (pull_up_en ? 1'b1 : tgl_q);
endmodule
`default_nettype wire

// *** tb/igp_ctrl_tb.sv ***
/* Self-checking bench for the gate drive controller with a module model.
   Assumes the small safe timing parameters: 4, 3 and 20 cycles. */
`timescale 1ns/1ps
`default_nettype none
module igp_ctrl_tb;
  // *****************
  // Bench and wiring
  // *****************
  localparam int FLT = 20;
  logic                mclk        = 1'b0;
  logic                rst         = 1'b1;
  igp_pkg::igp_gates_s req         = '0;
  igp_pkg::igp_gates_s gate;
  igp_pkg::igp_gates_s sw;
  logic                fault_out_n;
  logic                fault_seen;
  logic                fault_event;
  logic                fault_long;
  logic                pull_up_en;
  logic                sc_trip     = 1'b0;
  logic                ld_uv       = 1'b0;
  logic                ot_trip     = 1'b0;
  logic [2:0]          hb_uv       = '0;
  int                  err_count   = 0;
  int                  checks_done = 0;
  logic [31:0]         rnd         = 32'h0000_68b0;
  logic [6:0]          exp_q[$];
  event                smp_ev;
  always #2 mclk = ~mclk;
  igp_ctrl #(.BLANK_CYC(4), .WIDTH_CYC(3), .FAULT_CYC(FLT)) dut_u (
    .mclk(mclk), .rst(rst), .req(req), .fault_out_n(fault_out_n), .gate(gate),
    .fault_seen(fault_seen), .fault_event(fault_event), .fault_long(fault_long),
    .pull_up_en(pull_up_en));
  igp_dev_model #(.PULSE(FLT)) dev_u (
    .mclk(mclk), .gate(gate), .pull_up_en(pull_up_en), .sc_trip(sc_trip),
    .ld_uv(ld_uv), .ot_trip(ot_trip), .hb_uv(hb_uv), .sw(sw),
    .fault_out_n(fault_out_n));
  // Inputs always move 1 ns after the edge to stay clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [6:0] seen, input logic [6:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic expect_st(input logic [6:0] v);
    exp_q.push_back(v);
    ->smp_ev;
  endtask
  // Watcher takes the oldest note whenever a result is due
  always @(smp_ev) check("gate_fault", {gate, fault_seen}, exp_q.pop_front());
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Whole run is near 710 cycles; a hang is cut at 4000
  initial begin
    cyc(4000);
    err_count++;
    give_verdict();
  end
  initial begin
    int n;
    cyc(12);
    rst = 1'b0;
    cyc(3);
    check("pull_up_en", 7'(pull_up_en), 7'h01);
    check("fault_idle", {5'h00, fault_seen, fault_event}, 7'h00);
    // Random patterns with at most one switch of each leg asked on
    for (int k = 0; k < 6; k++) begin
      rnd = xs(rnd);
      req.low = rnd[2:0];
      req.high = rnd[5:3] & ~rnd[2:0];
      cyc(40);
      expect_st({req, 1'b0});
    end
    req = '0;
    cyc(40);
    req = 6'b001_001;
    cyc(40);
    expect_st(7'h00);
    // Overcurrent while all low switches are on
    req = 6'b000_111;
    cyc(40);
    sc_trip = 1'b1;
    #1 check("sw_sc", 7'(sw), 7'h00);
    cyc(1);
    sc_trip = 1'b0;
    for (n = 0; n < 10 && fault_event !== 1'b1; n++) cyc(1);
    check("fault_event", 7'(fault_event), 7'h01);
    cyc(10);
    check("fault_event_end", 7'(fault_event), 7'h00);
    expect_st(7'b000_000_1);
    cyc(30);
    expect_st(7'b000_000_0);
    req.low = 3'b110;
    cyc(10);
    req.low = 3'b111;
    cyc(20);
    expect_st(7'b000_001_0);
    check("sw_rearm", 7'(sw), 7'h01);
    // Overheat handed over to low supply, faults overlapping
    ot_trip = 1'b1;
    cyc(FLT + 20);
    check("fault_long", 7'(fault_long), 7'h01);
    ld_uv = 1'b1;
    cyc(5);
    ot_trip = 1'b0;
    cyc(40);
    expect_st(7'b000_000_1);
    ld_uv = 1'b0;
    cyc(30);
    expect_st(7'b000_000_0);
    check("fault_long_end", 7'(fault_long), 7'h00);
    req.low = 3'b000;
    cyc(10);
    req.low = 3'b001;
    cyc(20);
    check("sw_cool", 7'(sw), 7'h01);
    // Bootstrap supply dip on phase b high switch
    req.high = 3'b010;
    cyc(40);
    check("sw_high", 7'(sw), 7'h11);
    hb_uv[1] = 1'b1;
    cyc(20);
    check("sw_hbuv", 7'(sw), 7'h01);
    expect_st(7'b010_001_0);
    hb_uv[1] = 1'b0;
    cyc(20);
    check("sw_hbrec", 7'(sw), 7'h01);
    req.high = 3'b000;
    cyc(10);
    req.high = 3'b010;
    cyc(20);
    check("sw_hbedge", 7'(sw), 7'h11);
    cyc(2);
    give_verdict();
  end
endmodule
`default_nettype wire
